// *** ref_sel_pkg.sv ***
// constants, field layouts and codes for the reference input selector
package ref_sel_pkg;
    localparam int          ADDR_W        = 6;
    localparam int          DATA_W        = 32;
    localparam logic [5:0]  REG_CTRL      = 6'h00;
    localparam logic [5:0]  REG_PRIO1     = 6'h04;
    localparam logic [5:0]  REG_PRIO2     = 6'h08;
    localparam logic [5:0]  REG_MAN       = 6'h0c;
    localparam logic [5:0]  REG_BUF       = 6'h10;
    localparam logic [5:0]  REG_ROUTE     = 6'h14;
    localparam logic [5:0]  REG_VTIMER    = 6'h18;
    localparam logic [5:0]  REG_MON_EN    = 6'h1c;
    localparam logic [5:0]  REG_MATCH     = 6'h20;
    localparam logic [5:0]  REG_STATUS    = 6'h24;
    localparam logic [5:0]  REG_VALID     = 6'h28;
    // control register fields
    localparam int          CTRL_MODE1_LSB = 0;
    localparam int          CTRL_MODE2_LSB = 2;
    localparam int          CTRL_TCXO_PD   = 4;
    localparam logic [4:0]  CTRL_RST       = 5'h00;
    // priority: five slots of three bits, slot four is the loopback
    localparam int          SLOTS        = 5;
    localparam int          SLOT_LB      = 4;
    localparam int          PRIO_W       = 3;
    localparam logic [2:0]  PRIO_OFF     = 3'h0;
    localparam logic [2:0]  PRIO_LOWEST  = 3'h6;
    localparam logic [14:0] PRIO_RST     = 15'h0000;
    localparam logic [2:0]  SLOT_NONE    = 3'h7;
    // selected input codes
    localparam logic [2:0]  SEL_IN4      = 3'h4;
    localparam logic [2:0]  SEL_IN5      = 3'h5;
    localparam logic [2:0]  SEL_NONE     = 3'h7;
    localparam int          MAN_SEL1_LSB = 0;
    localparam int          MAN_SEL2_LSB = 3;
    localparam logic [5:0]  MAN_RST      = 6'h00;
    // buffer type codes, four bits per field: osc at 0, ref n at 4+4n
    localparam logic [3:0]  BUF_DC       = 4'h0;
    localparam logic [3:0]  BUF_AC_BIAS  = 4'h1;
    localparam logic [3:0]  BUF_AC_100   = 4'h3;
    localparam logic [3:0]  BUF_HCSL_50  = 4'h4;
    localparam logic [3:0]  BUF_SE_SLEW  = 4'h8;
    localparam logic [19:0] BUF_RST      = 20'h00000;
    // output routing, three bits per output
    localparam logic [2:0]  ROUTE_OFF    = 3'h0;
    localparam logic [2:0]  ROUTE_XO     = 3'h1;
    localparam logic [2:0]  ROUTE_TCXO   = 3'h2;
    localparam logic [2:0]  ROUTE_LOOP1  = 3'h3;
    localparam logic [2:0]  ROUTE_LOOP2  = 3'h4;
    localparam int          ROUTE_SECOND_OUTPUT_LSB = 3;
    localparam logic [5:0]  ROUTE_RST    = 6'h00;
    // validation timer and monitor enables (amp, freq, pulse per input)
    localparam int          VT_W         = 16;
    localparam logic [15:0] VTIMER_RST   = 16'h0100;
    localparam logic [11:0] MON_EN_RST   = 12'hfff;
    localparam logic [9:0]  MATCH_RST    = 10'h3ff;
    // synchroniser layout and reset (loss flags start asserted)
    localparam int          SYNC_W       = 22;
    localparam logic [21:0] SYNC_RST     = 22'h03ffff;
    localparam int          NUM_IN       = 6;
    typedef enum logic [1:0] {MODE_AUTO_REV, MODE_AUTO_NONREV, MODE_MAN_REG, MODE_MAN_PIN} mode_t;
endpackage

// *** reference_input_selector.sv ***
// reference input selection, buffer decode and output routing for two loops
`timescale 1ns/1ps
module reference_input_selector
    import ref_sel_pkg::*;
(
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire logic [ref_sel_pkg::ADDR_W-1:0] addr,
    input  wire logic [ref_sel_pkg::DATA_W-1:0] wdata,
    input  wire logic                      wr,
    input  wire logic                      rd,
    output logic      [ref_sel_pkg::DATA_W-1:0] rdata,
    input  wire logic [3:0]                diff_amp_los,
    input  wire logic [3:0]                slew_los,
    input  wire logic [3:0]                freq_los,
    input  wire logic [3:0]                pulse_los,
    input  wire logic [1:0]                loopback_los,
    input  wire logic [1:0]                sel_pins_loop1,
    input  wire logic [1:0]                sel_pins_loop2,
    output logic      [2:0]                selected_loop1,
    output logic      [2:0]                selected_loop2,
    output logic                           no_ref_loop1,
    output logic                           no_ref_loop2,
    output logic                           stable_osc_input_pd,
    output logic                           osc_term_100,
    output logic                           osc_term_50,
    output logic                           osc_bias,
    output logic      [3:0]                ref_term_100,
    output logic      [3:0]                ref_term_50,
    output logic      [3:0]                ref_bias,
    output logic      [3:0]                ref_slew_det,
    output logic      [2:0]                first_output_src,
    output logic      [2:0]                second_output_src
);
    import ref_sel_pkg::*;

    logic [4:0]           ctrl_q;
    logic [14:0]          prio_q [2];
    logic [5:0]           man_q;
    logic [19:0]          buf_q;
    logic [5:0]           route_q;
    logic [VT_W-1:0]      vtimer_q;
    logic [11:0]          mon_en_q;
    logic [9:0]           match_q;
    logic [SYNC_W-1:0]    sync1_q;
    logic [SYNC_W-1:0]    sync2_q;
    logic [VT_W-1:0]      cnt_q [NUM_IN];
    logic [NUM_IN-1:0]    valid_q;
    logic [NUM_IN-1:0]    flag_d;
    logic [2:0]           slot_q [2];
    logic [2:0]           slot_d [2];
    logic [4:0]           elig_d [2];
    logic [1:0]           none_q;
    logic [1:0]           none_d;
    logic [DATA_W-1:0]    rdata_q;

    function automatic logic [2:0] best_slot(input logic [14:0] prio, input logic [4:0] elig);
        logic [2:0] best;
        logic [2:0] bp;
        best = SLOT_NONE;
        bp   = SLOT_NONE;
        for (int i = 0; i < SLOTS; i++)
        begin
            // strict compare keeps the lower index on a tie
            if (elig[i] && prio[i*PRIO_W +: PRIO_W] != PRIO_OFF && prio[i*PRIO_W +: PRIO_W] <= PRIO_LOWEST
                && prio[i*PRIO_W +: PRIO_W] < bp)
            begin
                best = 3'(i);
                bp   = prio[i*PRIO_W +: PRIO_W];
            end
        end
        return best;
    endfunction

    // slot to input code; the loopback slot is chan2 for loop one, chan1 for loop two
    function automatic logic [2:0] slot_code(input logic [2:0] slot, input logic loop);
        if (slot == SLOT_NONE)
            return SEL_NONE;
        else if (slot == 3'(SLOT_LB))
            return loop ? SEL_IN4 : SEL_IN5;
        else
            return slot;
    endfunction

    // register writes
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q   <= CTRL_RST;
            prio_q[0] <= PRIO_RST;
            prio_q[1] <= PRIO_RST;
            man_q    <= MAN_RST;
            buf_q    <= BUF_RST;
            route_q  <= ROUTE_RST;
            vtimer_q <= VTIMER_RST;
            mon_en_q <= MON_EN_RST;
            match_q  <= MATCH_RST;
        end
        else if (wr)
        begin
            unique case (addr)
                REG_CTRL:   ctrl_q    <= wdata[4:0];
                REG_PRIO1:  prio_q[0] <= wdata[14:0];
                REG_PRIO2:  prio_q[1] <= wdata[14:0];
                REG_MAN:    man_q     <= wdata[5:0];
                REG_BUF:    buf_q     <= wdata[19:0];
                REG_ROUTE:  route_q   <= wdata[5:0];
                REG_VTIMER: vtimer_q  <= wdata[VT_W-1:0];
                REG_MON_EN: mon_en_q  <= wdata[11:0];
                REG_MATCH:  match_q   <= wdata[9:0];
                default:    ;
            endcase
        end
    end

    // register reads, data in the following cycle only
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= '0;
        else if (rd)
        begin
            unique case (addr)
                REG_CTRL:   rdata_q <= DATA_W'(ctrl_q);
                REG_PRIO1:  rdata_q <= DATA_W'(prio_q[0]);
                REG_PRIO2:  rdata_q <= DATA_W'(prio_q[1]);
                REG_MAN:    rdata_q <= DATA_W'(man_q);
                REG_BUF:    rdata_q <= DATA_W'(buf_q);
                REG_ROUTE:  rdata_q <= DATA_W'(route_q);
                REG_VTIMER: rdata_q <= DATA_W'(vtimer_q);
                REG_MON_EN: rdata_q <= DATA_W'(mon_en_q);
                REG_MATCH:  rdata_q <= DATA_W'(match_q);
                REG_STATUS: rdata_q <= DATA_W'({none_q, slot_code(slot_q[1], 1'b1),
                                                slot_code(slot_q[0], 1'b0)});
                REG_VALID:  rdata_q <= DATA_W'(valid_q);
                default:    rdata_q <= '0;
            endcase
        end
        else
            rdata_q <= '0;
    end
    assign rdata = rdata_q;

    // two-stage synchroniser for monitor flags and selection pins
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
        end
        else
        begin
            sync1_q <= {sel_pins_loop2, sel_pins_loop1, loopback_los, pulse_los, freq_los, slew_los, diff_amp_los};
            sync2_q <= sync1_q;
        end
    end

    // per-input flag: enabled monitors for references 0-3, amplitude detector picked by buffer type; loopback flags pass straight through
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            flag_d[i] = (mon_en_q[i*3] && ((buf_q[4+i*4 +: 4] == BUF_SE_SLEW) ? sync2_q[4+i] : sync2_q[i]))
                      || (mon_en_q[i*3+1] && sync2_q[8+i])
                      || (mon_en_q[i*3+2] && sync2_q[12+i]);
        end
        flag_d[4] = sync2_q[16];
        flag_d[5] = sync2_q[17];
    end

    // validation timers
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_IN; i++)
                cnt_q[i] <= '0;
            valid_q <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_IN; i++)
            begin
                if (flag_d[i])
                    cnt_q[i] <= '0;
                else if (cnt_q[i] < vtimer_q)
                    cnt_q[i] <= cnt_q[i] + 1'b1;
                valid_q[i] <= !flag_d[i] && cnt_q[i] >= vtimer_q;
            end
        end
    end

    // next selection per loop
    always_comb
    begin
        for (int l = 0; l < 2; l++)
        begin
            // both loops see all four references
            elig_d[l] = {valid_q[l == 0 ? 5 : 4], valid_q[3:0]} & match_q[l*5 +: 5];
            slot_d[l] = slot_q[l];
            unique case (mode_t'(ctrl_q[l*2 +: 2]))
                MODE_AUTO_REV:
                    slot_d[l] = best_slot(prio_q[l], elig_d[l]);
                MODE_AUTO_NONREV:
                begin
                    if (slot_q[l] == SLOT_NONE || !elig_d[l][slot_q[l]]
                        || prio_q[l][slot_q[l]*PRIO_W +: PRIO_W] == PRIO_OFF)
                        slot_d[l] = best_slot(prio_q[l], elig_d[l]);
                end
                MODE_MAN_REG:
                begin
                    if (man_q[l*3 +: 3] < SEL_IN4)
                        slot_d[l] = man_q[l*3 +: 3];
                    else if (man_q[l*3 +: 3] == (l == 0 ? SEL_IN5 : SEL_IN4))
                        slot_d[l] = 3'(SLOT_LB);
                    else
                        slot_d[l] = SLOT_NONE;
                end
                MODE_MAN_PIN:
                    slot_d[l] = {1'b0, sync2_q[18 + l*2 +: 2]};
            endcase
            none_d[l] = slot_d[l] == SLOT_NONE || !elig_d[l][slot_d[l]];
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slot_q[0] <= SLOT_NONE;
            slot_q[1] <= SLOT_NONE;
            none_q    <= 2'b11;
        end
        else
        begin
            slot_q[0] <= slot_d[0];
            slot_q[1] <= slot_d[1];
            none_q    <= none_d;
        end
    end

    // status pins
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            selected_loop1 <= SEL_NONE;
            selected_loop2 <= SEL_NONE;
            no_ref_loop1   <= 1'b1;
            no_ref_loop2   <= 1'b1;
        end
        else
        begin
            selected_loop1 <= slot_code(slot_d[0], 1'b0);
            selected_loop2 <= slot_code(slot_d[1], 1'b1);
            no_ref_loop1   <= none_d[0];
            no_ref_loop2   <= none_d[1];
        end
    end

    // buffer type decode and power down
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stable_osc_input_pd <= 1'b0;
            osc_term_100 <= 1'b0;
            osc_term_50  <= 1'b0;
            osc_bias     <= 1'b0;
            ref_term_100 <= '0;
            ref_term_50  <= '0;
            ref_bias     <= '0;
            ref_slew_det <= '0;
        end
        else
        begin
            stable_osc_input_pd <= ctrl_q[CTRL_TCXO_PD];
            osc_term_100 <= buf_q[3:0] == BUF_AC_100;
            osc_term_50  <= buf_q[3:0] == BUF_HCSL_50;
            osc_bias     <= buf_q[3:0] == BUF_AC_BIAS || buf_q[3:0] == BUF_AC_100;
            for (int i = 0; i < 4; i++)
            begin
                ref_term_100[i] <= buf_q[4+i*4 +: 4] == BUF_AC_100;
                ref_term_50[i]  <= buf_q[4+i*4 +: 4] == BUF_HCSL_50;
                ref_bias[i]     <= buf_q[4+i*4 +: 4] == BUF_AC_BIAS || buf_q[4+i*4 +: 4] == BUF_AC_100;
                ref_slew_det[i] <= buf_q[4+i*4 +: 4] == BUF_SE_SLEW;
            end
        end
    end

    // output routing; stable oscillator path is off while powered down
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            first_output_src  <= ROUTE_OFF;
            second_output_src <= ROUTE_OFF;
        end
        else
        begin
            first_output_src  <= (route_q[2:0] > ROUTE_LOOP2
                                  || (route_q[2:0] == ROUTE_TCXO && ctrl_q[CTRL_TCXO_PD]))
                                 ? ROUTE_OFF : route_q[2:0];
            second_output_src <= (route_q[5:3] > ROUTE_LOOP2
                                  || (route_q[5:3] == ROUTE_TCXO && ctrl_q[CTRL_TCXO_PD]))
                                 ? ROUTE_OFF : route_q[5:3];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    read_one_cycle_a: assert property (rd && addr == REG_STATUS |=> rdata[7:0] ==
        {$past(none_q), slot_code($past(slot_q[1]), 1'b1), slot_code($past(slot_q[0]), 1'b0)})
        else $error("status read data wrong");
    read_idle_zero_a: assert property (!rd |=> rdata == '0)
        else $error("read data outside read cycle");
    flag_clears_valid_a: assert property (flag_d[0] |=> !valid_q[0] ##1 !valid_q[0])
        else $error("input valid despite monitor flag");
    revertive_best_a: assert property (ctrl_q[1:0] == 2'(MODE_AUTO_REV) && elig_d[0][0]
        && prio_q[0][PRIO_W-1:0] == 3'h1 |=> slot_q[0] == 3'h0)
        else $error("revertive loop not on best input");
    nonrev_hold_a: assert property (ctrl_q[1:0] == 2'(MODE_AUTO_NONREV) && slot_q[0] != SLOT_NONE
        && elig_d[0][slot_q[0]] && prio_q[0][slot_q[0]*PRIO_W +: PRIO_W] != PRIO_OFF
        |=> slot_q[0] == $past(slot_q[0]))
        else $error("non-revertive loop switched from valid input");
    status_pin_a: assert property (selected_loop2 == slot_code(slot_q[1], 1'b1))
        else $error("status pin disagrees with selection");
    no_ref_a: assert property (slot_q[0] == SLOT_NONE |-> no_ref_loop1)
        else $error("no reference not reported");
    slew_decode_a: assert property ($rose(ref_slew_det[0]) |-> $past(buf_q[7:4]) == BUF_SE_SLEW)
        else $error("slew detect without single-ended type");
    pd_route_a: assert property (ctrl_q[CTRL_TCXO_PD] && route_q[2:0] == ROUTE_TCXO
        |=> first_output_src == ROUTE_OFF)
        else $error("powered-down input routed out");
    loopback_code_a: assert property (slot_q[0] == 3'(SLOT_LB) |-> selected_loop1 == SEL_IN5)
        else $error("loop one loopback code wrong");

    switch_cover_c: cover property (selected_loop1 != SEL_NONE ##1 selected_loop1 != $past(selected_loop1)
                                    && selected_loop1 != SEL_NONE);
    validate_cover_c: cover property ($rose(valid_q[0]));
    loss_cover_c: cover property ($rose(no_ref_loop2));
endmodule

// *** ref_monitor_model.sv ***
// input monitor stand-in driving loss flags for references and loopbacks
`timescale 1ns/1ps
module ref_monitor_model (
    input  wire logic       mclk,
    input  wire logic [5:0] healthy,
    input  wire logic [3:0] slew_mode,
    output logic      [3:0] diff_amp_los,
    output logic      [3:0] slew_los,
    output logic      [3:0] freq_los,
    output logic      [3:0] pulse_los,
    output logic      [1:0] loopback_los
);
    logic toggle_q;
    initial toggle_q = 1'b0;
    always @(posedge mclk)
    begin
        toggle_q <= ~toggle_q;
    end
    // the detector not in use chatters, so picking the wrong one shows up
    assign diff_amp_los = (slew_mode & {4{toggle_q}}) | (~slew_mode & ~healthy[3:0]);
    assign slew_los     = (~slew_mode & {4{toggle_q}}) | (slew_mode & ~healthy[3:0]);
    // flags held while an input is unhealthy
    assign freq_los     = ~healthy[3:0];
    assign pulse_los    = ~healthy[3:0];
    assign loopback_los = ~healthy[5:4];
endmodule

// *** reference_input_selector_tb.sv ***
// self-checking bench for the reference input selector
`timescale 1ns/1ps
module reference_input_selector_tb;
    import ref_sel_pkg::*;
    logic        mclk, rst_n, wr, rd;
    logic [5:0]  addr, healthy, h;
    logic [31:0] wdata, rdata, q;
    logic [3:0]  slew_mode, amp, slw, frq, pls, rt100, rt50, rbias, rslew;
    logic [1:0]  lb, pins1, pins2;
    logic [2:0]  sel1, sel2, e1, e2, fsrc, ssrc;
    logic        nr1, nr2, pd, ot100, ot50, obias;
    logic [14:0] p1, p2;
    logic [3:0]  codes [6];
    int          fails, check_count;

    ref_monitor_model u_mon (.mclk(mclk), .healthy(healthy), .slew_mode(slew_mode), .diff_amp_los(amp),
        .slew_los(slw), .freq_los(frq), .pulse_los(pls), .loopback_los(lb));
    reference_input_selector u_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .diff_amp_los(amp), .slew_los(slw), .freq_los(frq), .pulse_los(pls), .loopback_los(lb),
        .sel_pins_loop1(pins1), .sel_pins_loop2(pins2), .selected_loop1(sel1), .selected_loop2(sel2),
        .no_ref_loop1(nr1), .no_ref_loop2(nr2), .stable_osc_input_pd(pd), .osc_term_100(ot100),
        .osc_term_50(ot50), .osc_bias(obias), .ref_term_100(rt100), .ref_term_50(rt50), .ref_bias(rbias),
        .ref_slew_det(rslew), .first_output_src(fsrc), .second_output_src(ssrc));

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    // best valid slot by priority, lower index wins a tie
    function automatic logic [2:0] best(input logic [14:0] p, input logic [4:0] v, input logic [2:0] lbc);
        logic [2:0] r;
        logic [2:0] bp;
        r  = SEL_NONE;
        bp = 3'h7;
        for (int i = 0; i < SLOTS; i++)
            if (v[i] && p[i*3+:3] != PRIO_OFF && p[i*3+:3] < bp)
            begin
                bp = p[i*3+:3];
                r  = (i == SLOT_LB) ? lbc : 3'(i);
            end
        return r;
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #400000;
        fails++;
        give_verdict();
    end

    initial
    begin
        fails = 0; check_count = 0;
        rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 6'h00; wdata = 32'h0;
        healthy = 6'h00; slew_mode = 4'h0; pins1 = 2'h0; pins2 = 2'h0;
        codes = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h8, 4'h2};
        void'($urandom(32'h7c9f));
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        wait_clk(2);
        chk(sel1, SEL_NONE);
        chk(nr1, 1'b1);
        rd_reg(REG_VTIMER, q); chk(q, VTIMER_RST);
        rd_reg(REG_MON_EN, q); chk(q, MON_EN_RST);
        rd_reg(REG_MATCH, q); chk(q, MATCH_RST);
        rd_reg(REG_PRIO1, q); chk(q, PRIO_RST);
        wr_reg(6'h3c, 32'hffff_ffff);
        rd_reg(6'h3c, q); chk(q, 32'h0);
        $display("test reset done");
        wr_reg(REG_VTIMER, 32'h8);
        wr_reg(REG_PRIO1, 32'h0048);
        healthy <= 6'h06;
        wait_clk(4); chk(sel1, SEL_NONE);
        wait_clk(30); chk(sel1, 3'h1);
        wr_reg(REG_MATCH, 32'h3fd);
        wait_clk(3); chk(sel1, 3'h2);
        wr_reg(REG_MATCH, 32'h3ff);
        $display("test qualify done");
        wr_reg(REG_CTRL, 32'h4);
        wr_reg(REG_PRIO1, 32'h0401);
        wr_reg(REG_PRIO2, 32'h0401);
        healthy <= 6'h08;
        wait_clk(30); chk(sel1, 3'h3); chk(sel2, 3'h3);
        healthy <= 6'h09;
        wait_clk(30); chk(sel1, 3'h0); chk(sel2, 3'h3);
        healthy <= 6'h01;
        wait_clk(30); chk(sel2, 3'h0);
        $display("test policy done");
        wr_reg(REG_CTRL, 32'h0);
        for (int k = 0; k < 24; k++)
        begin
            h = 6'($urandom);
            p1 = 15'($urandom);
            p2 = 15'($urandom);
            wr_reg(REG_PRIO1, {17'h0, p1});
            wr_reg(REG_PRIO2, {17'h0, p2});
            healthy <= h;
            wait_clk(30);
            e1 = best(p1, {h[5], h[3:0]}, SEL_IN5);
            e2 = best(p2, {h[4], h[3:0]}, SEL_IN4);
            chk(sel1, e1);
            chk(sel2, e2);
            chk(nr1, e1 == SEL_NONE);
            chk(nr2, e2 == SEL_NONE);
            rd_reg(REG_STATUS, q);
            chk(q, {24'h0, e2 == SEL_NONE, e1 == SEL_NONE, e2, e1});
        end
        $display("test random done");
        wr_reg(REG_CTRL, 32'he);
        for (int c = 0; c < 6; c++)
        begin
            wr_reg(REG_MAN, 32'(c));
            wait_clk(3); chk(sel1, (c == 4) ? SEL_NONE : 3'(c));
        end
        for (int p = 0; p < 4; p++)
        begin
            pins2 <= 2'(p);
            wait_clk(6); chk(sel2, 3'(p));
        end
        $display("test manual done");
        wr_reg(REG_CTRL, 32'h0);
        foreach (codes[i])
        begin
            wr_reg(REG_BUF, {12'h0, {5{codes[i]}}});
            wait_clk(3);
            chk({ot100, ot50, obias}, {codes[i] == 4'h3, codes[i] == 4'h4, codes[i] == 4'h1 || codes[i] == 4'h3});
            chk(rt100, {4{codes[i] == 4'h3}});
            chk(rt50, {4{codes[i] == 4'h4}});
            chk(rbias, {4{codes[i] == 4'h1 || codes[i] == 4'h3}});
            chk(rslew, {4{codes[i] == 4'h8}});
        end
        wr_reg(REG_BUF, 32'h88880);
        wr_reg(REG_PRIO1, 32'h0001);
        slew_mode <= 4'hf;
        healthy <= 6'h01;
        wait_clk(30); chk(sel1, 3'h0);
        healthy <= 6'h00;
        wait_clk(30); chk({nr1, sel1}, {1'b1, SEL_NONE});
        $display("test buffers done");
        for (int c = 0; c < 5; c++)
        begin
            wr_reg(REG_ROUTE, {26'h0, 3'(4 - c), 3'(c)});
            wait_clk(3); chk({fsrc, ssrc}, {3'(c), 3'(4 - c)});
        end
        wr_reg(REG_CTRL, 32'h10);
        wr_reg(REG_ROUTE, {26'h0, ROUTE_LOOP1, ROUTE_TCXO});
        wait_clk(3); chk({pd, fsrc, ssrc}, {1'b1, ROUTE_OFF, ROUTE_LOOP1});
        $display("test routing done");
        @(posedge mclk);
        rst_n <= 1'b0;
        wait_clk(2);
        chk({pd, nr1, nr2, fsrc, ssrc, sel1, sel2},
            {1'b0, 2'b11, ROUTE_OFF, ROUTE_OFF, SEL_NONE, SEL_NONE});
        @(posedge mclk);
        rst_n <= 1'b1;
        rd_reg(REG_ROUTE, q); chk(q, ROUTE_RST);
        $display("test midrun reset done");
        give_verdict();
    end
endmodule
